// File: hw/debug_mode_pin_and_port_mux.sv
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module debug_mode_pin_and_port_mux
  import pin_mux_pkg::*;
#(
  parameter int NUM_PINS = PORT_PINS
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_PINS-1:0] pad_in_i,
  output logic [NUM_PINS-1:0] pad_out_o,
  output logic [NUM_PINS-1:0] pad_oe_o,
  output logic [NUM_PINS-1:0] pad_pull_en_o,
  output logic [NUM_PINS-1:0] pad_pull_down_o,
  input wire logic [NUM_PINS-1:0] periph_own_i,
  input wire logic [NUM_PINS-1:0] periph_oe_i,
  input wire logic [NUM_PINS-1:0] periph_out_i,
  input wire logic [KBD_PINS-1:0] kbd_pin_en_i,
  input wire logic kbd_rising_i,
  input wire logic irq_en_i,
  input wire logic irq_rising_i,
  output logic irq_pull_en_o,
  output logic irq_pull_down_o,
  input wire logic debug_mode_select_pin_i,
  output logic debug_mode_select_pin_o,
  output logic debug_mode_select_pin_oe_o,
  output logic debug_mode_o,
  input wire logic tx_req_i,
  input wire logic tx_bit_i,
  output logic tx_done_o,
  output logic rx_valid_o,
  output logic rx_bit_o,
  output logic link_busy_o
);

  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic dbg_s1;
    logic dbg_s2;
    logic dbg_prev;
    logic [1:0] boot_cnt;
    logic boot_done;
    logic debug_mode;
    logic [NUM_PINS-1:0] data;
    logic [NUM_PINS-1:0] dir;
    logic [NUM_PINS-1:0] pull;
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] rdata;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] pull_en;
    logic [NUM_PINS-1:0] pull_down;
    logic irq_pull_en;
    logic irq_pull_down;
    logic dbg_out;
    logic dbg_oe;
    logic tx_active;
    logic rx_active;
    logic [3:0] bit_cnt;
    logic [3:0] low_len;
    logic tx_done;
    logic rx_valid;
    logic rx_bit;
    logic busy;
  } state_t;

  localparam int HI_W = NUM_PINS - DATA_W;

  state_t st_r;
  state_t st_nxt;

  // lower or upper word of a pin-wide vector
  function automatic logic [DATA_W-1:0] pin_word(input logic [NUM_PINS-1:0] v,
                                                 input logic hi);
    logic [DATA_W-1:0] w;
    w = '0;
    if (hi) begin
      w[HI_W-1:0] = v[NUM_PINS-1:DATA_W];
    end else begin
      w = v[DATA_W-1:0];
    end
    return w;
  endfunction

  // write one word of a pin-wide vector
  function automatic logic [NUM_PINS-1:0] pin_merge(input logic [NUM_PINS-1:0] v,
                                                    input logic [DATA_W-1:0] d,
                                                    input logic hi);
    logic [NUM_PINS-1:0] r;
    r = v;
    if (hi) begin
      r[NUM_PINS-1:DATA_W] = d[HI_W-1:0];
    end else begin
      r[DATA_W-1:0] = d;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [NUM_PINS-1:0] oe_eff;
    logic [NUM_PINS-1:0] read_val;
    logic fall;
    logic link_up;
    oe_eff = '0;
    read_val = '0;
    fall = 1'b0;
    link_up = 1'b0;
    st_nxt = st_r;
    // pad levels are asynchronous: two flops before anything reads them
    st_nxt.sync1 = pad_in_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.dbg_s1 = debug_mode_select_pin_i;
    st_nxt.dbg_s2 = st_r.dbg_s1;
    st_nxt.dbg_prev = st_r.dbg_s2;
    st_nxt.tx_done = 1'b0;
    st_nxt.rx_valid = 1'b0;

    // the synchroniser needs two edges before the mode level can be trusted
    if (!st_r.boot_done) begin
      if (st_r.boot_cnt == BOOT_WAIT) begin
        st_nxt.boot_done = 1'b1;
        st_nxt.debug_mode = ~st_r.dbg_s2;
      end else begin
        st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
      end
    end
    // mode held: no other path writes debug_mode

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    if (wr_i) begin
      unique case (addr_i)
        OFS_DATA_LO: st_nxt.data = pin_merge(st_r.data, wdata_i, 1'b0);
        OFS_DATA_HI: st_nxt.data = pin_merge(st_r.data, wdata_i, 1'b1);
        OFS_DIR_LO: st_nxt.dir = pin_merge(st_r.dir, wdata_i, 1'b0);
        OFS_DIR_HI: st_nxt.dir = pin_merge(st_r.dir, wdata_i, 1'b1);
        OFS_PULL_LO: st_nxt.pull = pin_merge(st_r.pull, wdata_i, 1'b0);
        OFS_PULL_HI: st_nxt.pull = pin_merge(st_r.pull, wdata_i, 1'b1);
        OFS_CTRL: st_nxt.ctrl = wdata_i[CTRL_W-1:0];
        default: ;
      endcase
    end

    // latch or pin by direction, ownership ignored
    for (int i = 0; i < NUM_PINS; i++) begin
      read_val[i] = st_r.dir[i] ? st_r.data[i] : st_r.sync2[i];
    end

    // read data stands only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        OFS_DATA_LO: st_nxt.rdata = pin_word(read_val, 1'b0);
        OFS_DATA_HI: st_nxt.rdata = pin_word(read_val, 1'b1);
        OFS_DIR_LO: st_nxt.rdata = pin_word(st_r.dir, 1'b0);
        OFS_DIR_HI: st_nxt.rdata = pin_word(st_r.dir, 1'b1);
        OFS_PULL_LO: st_nxt.rdata = pin_word(st_r.pull, 1'b0);
        OFS_PULL_HI: st_nxt.rdata = pin_word(st_r.pull, 1'b1);
        OFS_CTRL: st_nxt.rdata[CTRL_W-1:0] = st_r.ctrl;
        OFS_STATUS: begin
          st_nxt.rdata[STAT_DEBUG_MODE] = st_r.debug_mode;
          st_nxt.rdata[STAT_BOOT_DONE] = st_r.boot_done;
          st_nxt.rdata[STAT_PIN_LEVEL] = st_r.dbg_s2;
        end
        default: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // port pins
    for (int i = 0; i < NUM_PINS; i++) begin
      oe_eff[i] = periph_own_i[i] ? periph_oe_i[i] : st_r.dir[i];
      st_nxt.pad_oe[i] = oe_eff[i];
      st_nxt.pad_out[i] = periph_own_i[i] ? periph_out_i[i] : st_r.data[i];
      st_nxt.pull_en[i] = st_r.pull[i] & ~oe_eff[i];
      st_nxt.pull_down[i] = 1'b0;
    end
    for (int k = 0; k < KBD_PINS; k++) begin
      st_nxt.pull_down[KBD_PIN_LO + k] = kbd_pin_en_i[k] & kbd_rising_i
                                         & st_nxt.pull_en[KBD_PIN_LO + k];
    end
    st_nxt.irq_pull_en = st_r.ctrl[CTRL_IRQ_PULL] & irq_en_i;
    st_nxt.irq_pull_down = st_r.ctrl[CTRL_IRQ_PULL] & irq_en_i & irq_rising_i;

    ////////////////////////////////////////////////////////////////////////////
    // shared debug pin
    // link after reset
    link_up = st_r.boot_done & ~st_r.ctrl[CTRL_PORTG_USE];
    fall = st_r.dbg_prev & ~st_r.dbg_s2;
    st_nxt.dbg_oe = 1'b0;
    st_nxt.dbg_out = 1'b1;

    if (st_r.tx_active || st_r.rx_active) begin
      st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
      if (st_r.rx_active && st_r.bit_cnt == SAMPLE_AT) begin
        st_nxt.rx_bit = st_r.dbg_s2;
      end
      if (st_r.bit_cnt == BIT_LAST) begin
        st_nxt.tx_active = 1'b0;
        st_nxt.rx_active = 1'b0;
        st_nxt.bit_cnt = 4'h0;
        st_nxt.tx_done = st_r.tx_active;
        st_nxt.rx_valid = st_r.rx_active;
      end
    end else if (link_up && tx_req_i) begin
      st_nxt.tx_active = 1'b1;
      st_nxt.low_len = tx_bit_i ? ONE_LOW : ZERO_LOW;
      st_nxt.bit_cnt = 4'h0;
    end else if (link_up && fall) begin
      st_nxt.rx_active = 1'b1;
      // two cycles of the bit are already lost in the synchroniser
      st_nxt.bit_cnt = 4'h2;
    end
    // busy kept in a flop so the output comes straight from a register
    st_nxt.busy = st_nxt.tx_active | st_nxt.rx_active;

    if (st_nxt.tx_active) begin
      if (st_nxt.bit_cnt < st_nxt.low_len) begin
        st_nxt.dbg_oe = 1'b1;
        st_nxt.dbg_out = 1'b0;
      end else if (st_nxt.bit_cnt == st_nxt.low_len) begin
        // speedup pulse, then pull-up holds the line
        st_nxt.dbg_oe = 1'b1;
        st_nxt.dbg_out = 1'b1;
      end
    end

    if (st_r.boot_done && st_r.ctrl[CTRL_PORTG_USE]) begin
      st_nxt.dbg_oe = 1'b1;
      st_nxt.dbg_out = st_r.ctrl[CTRL_PORTG_OUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      // pull-up idles the lines high
      st_r.sync1 <= '1;
      st_r.sync2 <= '1;
      st_r.dbg_s1 <= 1'b1;
      st_r.dbg_s2 <= 1'b1;
      st_r.dbg_prev <= 1'b1;
      st_r.data <= DATA_RST;
      st_r.dir <= DIR_RST;
      st_r.pull <= PULL_RST;
      st_r.ctrl <= CTRL_RST;
      st_r.low_len <= ONE_LOW;
      st_r.dbg_oe <= 1'b0;
      st_r.dbg_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign pad_out_o = st_r.pad_out;
  assign pad_oe_o = st_r.pad_oe;
  assign pad_pull_en_o = st_r.pull_en;
  assign pad_pull_down_o = st_r.pull_down;
  assign irq_pull_en_o = st_r.irq_pull_en;
  assign irq_pull_down_o = st_r.irq_pull_down;
  assign debug_mode_select_pin_o = st_r.dbg_out;
  assign debug_mode_select_pin_oe_o = st_r.dbg_oe;
  assign debug_mode_o = st_r.debug_mode;
  assign tx_done_o = st_r.tx_done;
  assign rx_valid_o = st_r.rx_valid;
  assign rx_bit_o = st_r.rx_bit;
  assign link_busy_o = st_r.busy;

endmodule

// File: hw/pin_mux_pkg.sv
package pin_mux_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int PORT_PINS = 55;
  // register byte offsets
  localparam logic [4:0] OFS_DATA_LO = 5'h00;
  localparam logic [4:0] OFS_DATA_HI = 5'h04;
  localparam logic [4:0] OFS_DIR_LO = 5'h08;
  localparam logic [4:0] OFS_DIR_HI = 5'h0C;
  localparam logic [4:0] OFS_PULL_LO = 5'h10;
  localparam logic [4:0] OFS_PULL_HI = 5'h14;
  localparam logic [4:0] OFS_CTRL = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1C;
  // control fields
  localparam int CTRL_PORTG_OUT = 0;
  localparam int CTRL_PORTG_USE = 1;
  localparam int CTRL_IRQ_PULL = 2;
  localparam int CTRL_W = 3;
  // status fields
  localparam int STAT_DEBUG_MODE = 0;
  localparam int STAT_BOOT_DONE = 1;
  localparam int STAT_PIN_LEVEL = 2;
  // reset values
  localparam logic [PORT_PINS-1:0] DATA_RST = '0;
  localparam logic [PORT_PINS-1:0] DIR_RST = '0;
  localparam logic [PORT_PINS-1:0] PULL_RST = '0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  // port A upper pins sit at these indices of the pin vector
  localparam int KBD_PIN_LO = 4;
  localparam int KBD_PINS = 4;
  // debug link timing, in debug clock cycles
  localparam int BIT_CYCLES = 16;
  localparam logic [3:0] BIT_LAST = 4'(BIT_CYCLES - 1);
  localparam logic [3:0] ONE_LOW = 4'h4;
  localparam logic [3:0] ZERO_LOW = 4'hD;
  localparam logic [3:0] SAMPLE_AT = 4'hA;
  // cycles after reset release before the synchronised mode level is valid
  localparam logic [1:0] BOOT_WAIT = 2'h2;
endpackage

// File: verification/debug_pod.sv
`timescale 1ns/1ps
// debug pod on the shared pin; the testbench resolves the wire with the pull-up
module debug_pod (
  input wire logic clock_i,
  output logic pod_oe_o,
  output logic pod_out_o
);
  initial begin
    pod_oe_o = 1'b0;
    pod_out_o = 1'b1;
  end
  task automatic hold_low(input logic on);
    @(posedge clock_i);
    pod_oe_o <= on;
    pod_out_o <= 1'b0;
  endtask
  task automatic send(input logic b);
    @(posedge clock_i);
    pod_oe_o <= 1'b1;
    pod_out_o <= 1'b0;
    repeat (b ? 4 : 13) @(posedge clock_i);
    pod_out_o <= 1'b1;
    @(posedge clock_i);
    pod_oe_o <= 1'b0;
    repeat (b ? 11 : 2) @(posedge clock_i);
  endtask
endmodule

// File: verification/pin_mux_sva.sv
`timescale 1ns/1ps
module pin_mux_sva
  import pin_mux_pkg::*;
#(
  parameter int NUM_PINS = PORT_PINS
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [NUM_PINS-1:0] pad_out_o,
  input wire logic [NUM_PINS-1:0] pad_oe_o,
  input wire logic [NUM_PINS-1:0] pad_pull_en_o,
  input wire logic [NUM_PINS-1:0] pad_pull_down_o,
  input wire logic [NUM_PINS-1:0] periph_own_i,
  input wire logic [NUM_PINS-1:0] periph_oe_i,
  input wire logic [NUM_PINS-1:0] periph_out_i,
  input wire logic [KBD_PINS-1:0] kbd_pin_en_i,
  input wire logic kbd_rising_i,
  input wire logic irq_en_i,
  input wire logic irq_rising_i,
  input wire logic irq_pull_en_o,
  input wire logic irq_pull_down_o,
  input wire logic debug_mode_select_pin_i,
  input wire logic debug_mode_select_pin_o,
  input wire logic debug_mode_select_pin_oe_o,
  input wire logic debug_mode_o,
  input wire logic tx_bit_i,
  input wire logic tx_done_o,
  input wire logic link_busy_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  sequence low_phase;
    debug_mode_select_pin_oe_o && !debug_mode_select_pin_o;
  endsequence
  sequence speedup;
    debug_mode_select_pin_oe_o && debug_mode_select_pin_o ##1 !debug_mode_select_pin_oe_o;
  endsequence
  sequence tx_start;
    $rose(link_busy_o) and low_phase;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  boot_quiet_a: assert property (
    $rose(resetn_i) |-> !debug_mode_select_pin_oe_o) else $error("pin driven at reset release");
  mode_debug_a: assert property (
    $rose(resetn_i) && !debug_mode_select_pin_i ##1 !debug_mode_select_pin_i |-> ##2 debug_mode_o)
    else $error("debug mode not entered");
  mode_normal_a: assert property (
    $rose(resetn_i) && debug_mode_select_pin_i ##1 debug_mode_select_pin_i |-> ##2 !debug_mode_o)
    else $error("normal mode not entered");
  mode_latch_a: assert property (
    $changed(debug_mode_o) |-> $past(resetn_i, 3) && !$past(resetn_i, 4))
    else $error("mode changed after boot");
  one_shape_a: assert property (
    tx_start and $past(tx_bit_i) |-> low_phase [*4] ##1 speedup) else $error("one bit shape");
  zero_shape_a: assert property (
    tx_start and !$past(tx_bit_i) |-> low_phase [*8] ##1 low_phase [*5] ##1 speedup)
    else $error("zero bit shape");
  bit_time_a: assert property (
    tx_start |-> ##16 tx_done_o) else $error("bit time not 16 cycles");
  periph_oe_a: assert property (
    periph_own_i != '0 |=> ((pad_oe_o ^ $past(periph_oe_i)) & $past(periph_own_i)) == '0)
    else $error("owned pin enable wrong");
  periph_out_a: assert property (
    periph_own_i != '0 |=> ((pad_out_o ^ $past(periph_out_i)) & $past(periph_own_i)) == '0)
    else $error("owned pin value wrong");
  pull_input_a: assert property (
    (pad_pull_en_o & pad_oe_o) == '0) else $error("pull on driven pin");
  kbd_down_a: assert property (
    kbd_rising_i && (&kbd_pin_en_i) |=>
      pad_pull_down_o[KBD_PIN_LO +: KBD_PINS] == pad_pull_en_o[KBD_PIN_LO +: KBD_PINS])
    else $error("keyboard pull-down wrong");
  no_down_a: assert property (
    !kbd_rising_i |=> pad_pull_down_o == '0) else $error("pull-down without rising");
  irq_down_a: assert property (
    irq_en_i && irq_rising_i |=> irq_pull_down_o == irq_pull_en_o) else $error("irq pull-down");
  read_idle_a: assert property (
    !rd_i |=> rdata_o == '0) else $error("read data outside read cycle");
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pin_mux_pkg::*;
  logic clock_i, resetn_i, wr_i, rd_i, kbd_rising_i, irq_en_i, irq_rising_i, tx_req_i, tx_bit_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic [PORT_PINS-1:0] pad_in_i, pad_out_o, pad_oe_o, pad_pull_en_o, pad_pull_down_o;
  logic [PORT_PINS-1:0] periph_own_i, periph_oe_i, periph_out_i;
  logic [KBD_PINS-1:0] kbd_pin_en_i;
  logic irq_pull_en_o, irq_pull_down_o, debug_mode_select_pin_i, debug_mode_select_pin_o;
  logic debug_mode_select_pin_oe_o, debug_mode_o, tx_done_o, rx_valid_o, rx_bit_o, link_busy_o;
  logic pod_oe_o, pod_out_o;
  int num_errors = 0;
  int comparisons = 0;
  debug_mode_pin_and_port_mux #(.NUM_PINS(PORT_PINS)) uut (.*);
  debug_pod pod (.*);
  // released line floats up through the pin's pull-up
  assign debug_mode_select_pin_i = debug_mode_select_pin_oe_o ? debug_mode_select_pin_o :
                                   (pod_oe_o ? pod_out_o : 1'b1);
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  task automatic rst(input logic low);
    pod.hold_low(low);
    resetn_i <= 1'b0;
    step(3);
    chk(debug_mode_select_pin_oe_o, 0);
    step(3);
    resetn_i <= 1'b1;
    step(4);
    pod.hold_low(1'b0);
    step(2);
  endtask
  task automatic tx(input logic b);
    int n;
    @(posedge clock_i);
    tx_req_i <= 1'b1;
    tx_bit_i <= b;
    @(posedge clock_i);
    tx_req_i <= 1'b0;
    #1;
    chk(link_busy_o, 1);
    n = 0;
    while (tx_done_o !== 1'b1 && n < 40) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk(n, 16);
  endtask
  task automatic rx(input logic b);
    int n;
    n = 0;
    fork
      pod.send(b);
      while (rx_valid_o !== 1'b1 && n < 40) begin
        @(posedge clock_i);
        #1;
        n++;
      end
    join
    chk(rx_bit_o, b);
    chk(n < 40, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, wr_i, rd_i, kbd_rising_i, irq_en_i, irq_rising_i, tx_req_i, tx_bit_i} = '0;
    {addr_i, wdata_i, kbd_pin_en_i} = '0;
    {pad_in_i, periph_own_i, periph_oe_i, periph_out_i} = '0;
    rst(1'b1);
    rd(OFS_STATUS, 32'h7);
    tx(1'b1);
    tx(1'b0);
    rx(1'b0);
    rx(1'b1);
    chk(debug_mode_o, 1);
    rst(1'b0);
    rd(OFS_STATUS, 32'h6);
    chk(pad_oe_o, 0);
    chk(pad_pull_en_o, 0);
    rd(OFS_DIR_HI, 32'h0);
    rd(OFS_PULL_LO, 32'h0);
    wr(OFS_DIR_HI, 32'hFFFFFFFF);
    rd(OFS_DIR_HI, 32'h007FFFFF);
    chk(pad_oe_o[PORT_PINS-1:32], 23'h7FFFFF);
    wr(OFS_DIR_HI, 32'h0);
    wr(5'h02, 32'hFFFFFFFF);
    rd(5'h02, 32'h0);
    wr(OFS_CTRL, 32'h3);
    step(2);
    chk({debug_mode_select_pin_oe_o, debug_mode_select_pin_o}, 2'h3);
    wr(OFS_CTRL, 32'h2);
    step(2);
    chk({debug_mode_select_pin_oe_o, debug_mode_select_pin_o}, 2'h2);
    wr(OFS_CTRL, 32'h0);
    step(1);
    pad_in_i <= 55'h2A;
    periph_own_i <= 55'h21;
    periph_oe_i <= 55'h1;
    periph_out_i <= 55'h1;
    wr(OFS_DATA_LO, 32'h1);
    wr(OFS_DIR_LO, 32'h0);
    step(2);
    chk({pad_oe_o[7:0], pad_out_o[0]}, 9'h3);
    rd(OFS_DATA_LO, 32'h2A);
    wr(OFS_DIR_LO, 32'h21);
    rd(OFS_DATA_LO, 32'h0B);
    chk(pad_oe_o[7:0], 8'h01);
    wr(OFS_PULL_LO, 32'hF1);
    kbd_pin_en_i <= 4'hF;
    kbd_rising_i <= 1'b1;
    step(2);
    chk(pad_pull_en_o[7:0], 8'hF0);
    chk(pad_pull_down_o[7:0], 8'hF0);
    kbd_rising_i <= 1'b0;
    step(2);
    chk(pad_pull_down_o, 0);
    wr(OFS_CTRL, 32'h4);
    irq_en_i <= 1'b1;
    irq_rising_i <= 1'b1;
    step(2);
    chk({irq_pull_en_o, irq_pull_down_o}, 2'h3);
    irq_rising_i <= 1'b0;
    step(2);
    chk({irq_pull_en_o, irq_pull_down_o}, 2'h2);
    complete_run();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    step(3000);
    num_errors++;
    complete_run();
  end
endmodule
bind debug_mode_pin_and_port_mux pin_mux_sva #(.NUM_PINS(NUM_PINS)) chk_sva (.*);
